// file: spm_pkg.sv
package spm_pkg;

	// Register byte offsets on the Wishbone bus.
	localparam logic [7:0] SPM_SYS_CONFIG_OFS = 8'h00;
	localparam logic [7:0] SPM_IRQ_EDGE_PIN_SELECT_OFS = 8'h04;
	localparam logic [7:0] SPM_PORT_A_DATA_OFS = 8'h08;
	localparam logic [7:0] SPM_PORT_A_DIR_OFS = 8'h0C;
	localparam logic [7:0] SPM_PORT_B_DATA_OFS = 8'h10;
	localparam logic [7:0] SPM_PORT_B_DIR_OFS = 8'h14;
	localparam logic [7:0] SPM_PORT_C_DATA_OFS = 8'h18;
	localparam logic [7:0] SPM_PORT_C_DIR_OFS = 8'h1C;

	// Field positions in the system configuration register.
	localparam int SPM_CFG_HOST_BIT = 1;
	localparam int SPM_CFG_SYNC_B_BIT = 2;
	localparam int SPM_CFG_PB_LOW_BIT = 5;
	localparam int SPM_CFG_PB_HIGH_BIT = 6;
	localparam int SPM_CFG_PC_BIT = 7;

	// Field positions in the interrupt edge and pin select register.
	localparam int SPM_IRQ_DAISY_OUT_BIT = 2;
	localparam int SPM_IRQ_PORT_C2_BIT = 3;

	// Reset values.
	localparam logic [7:0] SPM_SYS_CONFIG_RST = 8'h00;
	localparam logic [7:0] SPM_IRQ_EDGE_PIN_SELECT_RST = 8'h00;
	localparam logic [7:0] SPM_PORT_DATA_RST = 8'h00;
	localparam logic [7:0] SPM_PORT_DIR_RST = 8'h00;

	// Shared package pins, one bit each; used for pin level, drive value and enable.
	typedef struct packed {
		logic [7:0] port_a;
		logic [7:0] port_b;
		logic [5:0] port_c;
		logic [2:0] tri_fn;
		logic daisy;
	} spm_pins_t;

	// Functions that the processor side offers to the pins.
	typedef struct packed {
		logic chan0_transmit;
		logic chan0_request_to_send_n;
		logic chan1_transmit;
		logic sync_a_wait_request_n;
		logic sync_a_terminal_ready_request_n;
		logic sync_a_request_to_send_n;
		logic sync_b_wait_request_n;
		logic sync_b_terminal_ready_request_n;
		logic sync_b_request_to_send_n;
		logic host_interrupt_out;
		logic host_tx_ready_out_n;
		logic host_rx_ready_out_n;
		logic memory_write_strobe_n;
		logic daisy_chain_out;
		logic [7:0] host_data_out;
		logic host_data_oe;
		logic [2:0] primary_out;
		logic [2:0] primary_oe;
	} spm_core_out_t;

	// Inputs that the pins deliver to the processor side.
	typedef struct packed {
		logic chan0_receive;
		logic chan0_clear_to_send_n;
		logic chan0_carrier_detect_n;
		logic chan1_receive;
		logic clocked_serial_rx_or_chan1_cts_n;
		logic sync_a_clear_to_send_n;
		logic sync_a_carrier_detect_n;
		logic sync_a_sync_pin_n;
		logic daisy_chain_in;
		logic [7:0] host_data_in;
		logic [2:0] primary_in;
	} spm_core_in_t;

	// Use of each triple-function pin.
	typedef enum logic [1:0] {
		SPM_TRI_PRIMARY = 2'b00,
		SPM_TRI_SYNC_B = 2'b01,
		SPM_TRI_HOST = 2'b11
	} spm_tri_sel_t;

endpackage

// file: spm_sync.sv
`timescale 1ns/1ps
module spm_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	// The first stage is only ever read by the second stage.
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;
endmodule

// file: spm_pin_mux.sv
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/1ps
// Overview of operation
// - Configuration bits 7 to 5 choose port or serial use of port B and C pins.
// - Bit 6 set gives port B bits 7 to 5 port use, else serial signals.
// - Bit 5 set gives port B bits 4 to 0 port use, else channel 0 signals.
// - Bit 7 set gives port C bits 5 to 0 port use, else sync channel A.
// - Port C bits 7 and 6 always read external interrupt two and one pins.
// - Port B bit 1 in port mode forces internal channel 0 clear-to-send low.
// - Select register bit 3 picks write strobe or port C2/request pair; bit 7 within.
// - Configuration bits 1 and 2 choose each triple-function pin's use.
// - Select register bit 2 makes the daisy-chain pin an input or an output.
module spm_pin_mux (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire spm_pkg::spm_pins_t pin_i,
	output spm_pkg::spm_pins_t pin_o,
	output spm_pkg::spm_pins_t pin_oe_o,
	input wire logic external_irq_one_n_i,
	input wire logic external_irq_two_n_i,
	input wire spm_pkg::spm_core_out_t core_out_i,
	output spm_pkg::spm_core_in_t core_in_o
);
	import spm_pkg::*;

	spm_pins_t pin_sync;
	logic [1:0] irq_sync;

	spm_sync #(
		.WIDTH($bits(spm_pins_t))
	) u_pin_sync (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.async_i(pin_i),
		.sync_o(pin_sync)
	);

	spm_sync #(
		.WIDTH(2)
	) u_irq_sync (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.async_i({external_irq_two_n_i, external_irq_one_n_i}),
		.sync_o(irq_sync)
	);

	function automatic logic pick(input logic port_mode, input logic port_val,
		input logic fn_val);
		pick = port_mode ? port_val : fn_val;
	endfunction

	function automatic spm_tri_sel_t tri_select(input logic [7:0] cfg);
		if (cfg[SPM_CFG_HOST_BIT]) begin
			tri_select = SPM_TRI_HOST;
		end else if (cfg[SPM_CFG_SYNC_B_BIT]) begin
			tri_select = SPM_TRI_SYNC_B;
		end else begin
			tri_select = SPM_TRI_PRIMARY;
		end
	endfunction

	// Register file and Wishbone slave.
	logic [7:0] sys_config_reg, sys_config_next;
	logic [7:0] irq_edge_pin_select_reg, irq_edge_pin_select_next;
	logic [7:0] port_a_data_reg, port_a_data_next;
	logic [7:0] port_a_dir_reg, port_a_dir_next;
	logic [7:0] port_b_data_reg, port_b_data_next;
	logic [7:0] port_b_dir_reg, port_b_dir_next;
	logic [7:0] port_c_data_reg, port_c_data_next;
	logic [7:0] port_c_dir_reg, port_c_dir_next;
	logic wb_ack_reg, wb_ack_next;
	logic [31:0] wb_dat_reg, wb_dat_next;
	logic bus_write;
	logic [7:0] rd_byte;

	always_comb begin
		sys_config_next = sys_config_reg;
		irq_edge_pin_select_next = irq_edge_pin_select_reg;
		port_a_data_next = port_a_data_reg;
		port_a_dir_next = port_a_dir_reg;
		port_b_data_next = port_b_data_reg;
		port_b_dir_next = port_b_dir_reg;
		port_c_data_next = port_c_data_reg;
		port_c_dir_next = port_c_dir_reg;
		// A write lands on the edge at which the master sees ack high.
		bus_write = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_reg && wb_sel_i[0];
		if (bus_write) begin
			unique case (wb_adr_i)
				SPM_SYS_CONFIG_OFS: sys_config_next = wb_dat_i[7:0];
				SPM_IRQ_EDGE_PIN_SELECT_OFS: irq_edge_pin_select_next = wb_dat_i[7:0];
				SPM_PORT_A_DATA_OFS: port_a_data_next = wb_dat_i[7:0];
				SPM_PORT_A_DIR_OFS: port_a_dir_next = wb_dat_i[7:0];
				SPM_PORT_B_DATA_OFS: port_b_data_next = wb_dat_i[7:0];
				SPM_PORT_B_DIR_OFS: port_b_dir_next = wb_dat_i[7:0];
				SPM_PORT_C_DATA_OFS: port_c_data_next = wb_dat_i[7:0];
				SPM_PORT_C_DIR_OFS: port_c_dir_next = wb_dat_i[7:0];
				default: ;
			endcase
		end
		// Data registers read back the pin levels, not the latched drive value.
		unique case (wb_adr_i)
			SPM_SYS_CONFIG_OFS: rd_byte = sys_config_reg;
			SPM_IRQ_EDGE_PIN_SELECT_OFS: rd_byte = irq_edge_pin_select_reg;
			SPM_PORT_A_DATA_OFS: rd_byte = pin_sync.port_a;
			SPM_PORT_A_DIR_OFS: rd_byte = port_a_dir_reg;
			SPM_PORT_B_DATA_OFS: rd_byte = pin_sync.port_b;
			SPM_PORT_B_DIR_OFS: rd_byte = port_b_dir_reg;
			SPM_PORT_C_DATA_OFS: rd_byte = {irq_sync, pin_sync.port_c};
			SPM_PORT_C_DIR_OFS: rd_byte = port_c_dir_reg;
			default: rd_byte = 8'h00;
		endcase
		wb_ack_next = wb_cyc_i && wb_stb_i && !wb_ack_reg;
		wb_dat_next = wb_ack_next ? {24'h00_0000, rd_byte} : 32'h0000_0000;
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			sys_config_reg <= SPM_SYS_CONFIG_RST;
			irq_edge_pin_select_reg <= SPM_IRQ_EDGE_PIN_SELECT_RST;
			port_a_data_reg <= SPM_PORT_DATA_RST;
			port_a_dir_reg <= SPM_PORT_DIR_RST;
			port_b_data_reg <= SPM_PORT_DATA_RST;
			port_b_dir_reg <= SPM_PORT_DIR_RST;
			port_c_data_reg <= SPM_PORT_DATA_RST;
			port_c_dir_reg <= SPM_PORT_DIR_RST;
			wb_ack_reg <= 1'b0;
			wb_dat_reg <= 32'h0000_0000;
		end else begin
			sys_config_reg <= sys_config_next;
			irq_edge_pin_select_reg <= irq_edge_pin_select_next;
			port_a_data_reg <= port_a_data_next;
			port_a_dir_reg <= port_a_dir_next;
			port_b_data_reg <= port_b_data_next;
			port_b_dir_reg <= port_b_dir_next;
			port_c_data_reg <= port_c_data_next;
			port_c_dir_reg <= port_c_dir_next;
			wb_ack_reg <= wb_ack_next;
			wb_dat_reg <= wb_dat_next;
		end
	end

	// Pin multiplexer. The selection itself is combinational; the result is
	// registered once so that every pin and core input leaves from a flip-flop.
	spm_pins_t pin_out_reg, pin_out_next;
	spm_pins_t pin_oe_reg, pin_oe_next;
	spm_core_in_t core_in_reg, core_in_next;
	logic pb_high_port;
	logic pb_low_port;
	logic pc_port;
	logic pc2_pair;
	logic host_mode;
	spm_tri_sel_t tri_sel;

	always_comb begin
		pb_high_port = sys_config_reg[SPM_CFG_PB_HIGH_BIT];
		pb_low_port = sys_config_reg[SPM_CFG_PB_LOW_BIT];
		pc_port = sys_config_reg[SPM_CFG_PC_BIT];
		pc2_pair = irq_edge_pin_select_reg[SPM_IRQ_PORT_C2_BIT];
		host_mode = sys_config_reg[SPM_CFG_HOST_BIT];
		tri_sel = tri_select(sys_config_reg);

		// Port A.
		pin_out_next.port_a = host_mode ? core_out_i.host_data_out : port_a_data_reg;
		pin_oe_next.port_a = host_mode ? {8{core_out_i.host_data_oe}} : port_a_dir_reg;
		core_in_next.host_data_in = host_mode ? pin_sync.port_a : 8'h00;

		// Port B: serial outputs on bits 5, 3 and 0, the rest are serial inputs.
		pin_out_next.port_b[7] = port_b_data_reg[7];
		pin_out_next.port_b[6] = port_b_data_reg[6];
		pin_out_next.port_b[5] = pick(pb_high_port, port_b_data_reg[5],
			core_out_i.chan1_transmit);
		pin_out_next.port_b[4] = port_b_data_reg[4];
		pin_out_next.port_b[3] = pick(pb_low_port, port_b_data_reg[3],
			core_out_i.chan0_transmit);
		pin_out_next.port_b[2] = port_b_data_reg[2];
		pin_out_next.port_b[1] = port_b_data_reg[1];
		pin_out_next.port_b[0] = pick(pb_low_port, port_b_data_reg[0],
			core_out_i.chan0_request_to_send_n);
		pin_oe_next.port_b[7:5] = pb_high_port ? port_b_dir_reg[7:5] : 3'b001;
		pin_oe_next.port_b[4:0] = pb_low_port ? port_b_dir_reg[4:0] : 5'b01001;

		// Serial inputs whose pins are in port mode sit at their idle level, except channel 0 clear-to-send.
		core_in_next.clocked_serial_rx_or_chan1_cts_n = pick(pb_high_port, 1'b1,
			pin_sync.port_b[7]);
		core_in_next.chan1_receive = pick(pb_high_port, 1'b1, pin_sync.port_b[6]);
		core_in_next.chan0_receive = pick(pb_low_port, 1'b1, pin_sync.port_b[4]);
		core_in_next.chan0_carrier_detect_n = pick(pb_low_port, 1'b1, pin_sync.port_b[2]);
		// Clear-to-send goes low, not idle, so channel 0 may still transmit.
		core_in_next.chan0_clear_to_send_n = pick(pb_low_port, 1'b0,
			pin_sync.port_b[1]);

		// Port C: outputs on bits 5, 3 and 2, inputs on 4, 1 and 0.
		pin_out_next.port_c[5] = pick(pc_port, port_c_data_reg[5],
			core_out_i.sync_a_wait_request_n);
		pin_out_next.port_c[4] = port_c_data_reg[4];
		pin_out_next.port_c[3] = pick(pc_port, port_c_data_reg[3],
			core_out_i.sync_a_terminal_ready_request_n);
		pin_out_next.port_c[1:0] = port_c_data_reg[1:0];
		pin_oe_next.port_c[5:3] = pc_port ? port_c_dir_reg[5:3] : 3'b101;
		pin_oe_next.port_c[1:0] = pc_port ? port_c_dir_reg[1:0] : 2'b00;
		if (!pc2_pair) begin
			pin_out_next.port_c[2] = core_out_i.memory_write_strobe_n;
			pin_oe_next.port_c[2] = 1'b1;
		end else begin
			pin_out_next.port_c[2] = pick(pc_port, port_c_data_reg[2],
				core_out_i.sync_a_request_to_send_n);
			pin_oe_next.port_c[2] = pc_port ? port_c_dir_reg[2] : 1'b1;
		end
		core_in_next.sync_a_sync_pin_n = pick(pc_port, 1'b1, pin_sync.port_c[4]);
		core_in_next.sync_a_clear_to_send_n = pick(pc_port, 1'b1, pin_sync.port_c[1]);
		core_in_next.sync_a_carrier_detect_n = pick(pc_port, 1'b1, pin_sync.port_c[0]);

		// Triple-function pins in sync B use: index 0 terminal ready, 1 wait, 2 request-to-send.
		unique case (tri_sel)
			SPM_TRI_HOST: begin
				pin_out_next.tri_fn = {core_out_i.host_rx_ready_out_n,
					core_out_i.host_tx_ready_out_n, core_out_i.host_interrupt_out};
				pin_oe_next.tri_fn = 3'b111;
			end
			SPM_TRI_SYNC_B: begin
				pin_out_next.tri_fn = {core_out_i.sync_b_request_to_send_n,
					core_out_i.sync_b_wait_request_n,
					core_out_i.sync_b_terminal_ready_request_n};
				pin_oe_next.tri_fn = 3'b111;
			end
			default: begin
				pin_out_next.tri_fn = core_out_i.primary_out;
				pin_oe_next.tri_fn = core_out_i.primary_oe;
			end
		endcase
		core_in_next.primary_in = (tri_sel == SPM_TRI_PRIMARY) ? pin_sync.tri_fn : 3'b000;

		// Daisy chain: an output pin leaves the internal chain input enabled.
		if (irq_edge_pin_select_reg[SPM_IRQ_DAISY_OUT_BIT]) begin
			pin_out_next.daisy = core_out_i.daisy_chain_out;
			pin_oe_next.daisy = 1'b1;
			core_in_next.daisy_chain_in = 1'b1;
		end else begin
			pin_out_next.daisy = 1'b0;
			pin_oe_next.daisy = 1'b0;
			core_in_next.daisy_chain_in = pin_sync.daisy;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			pin_out_reg <= '0;
			pin_oe_reg <= '0;
			core_in_reg <= '0;
		end else begin
			pin_out_reg <= pin_out_next;
			pin_oe_reg <= pin_oe_next;
			core_in_reg <= core_in_next;
		end
	end

	assign pin_o = pin_out_reg;
	assign pin_oe_o = pin_oe_reg;
	assign core_in_o = core_in_reg;
	assign wb_ack_o = wb_ack_reg;
	assign wb_dat_o = wb_dat_reg;
endmodule

// file: spm_pin_mux_asserts.sv
`timescale 1ns/1ps
module spm_pin_mux_chk (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire spm_pkg::spm_pins_t pin_i,
	input wire spm_pkg::spm_pins_t pin_o,
	input wire spm_pkg::spm_pins_t pin_oe_o,
	input wire logic external_irq_one_n_i,
	input wire logic external_irq_two_n_i,
	input wire spm_pkg::spm_core_out_t core_out_i,
	input wire spm_pkg::spm_core_in_t core_in_o
);
	import spm_pkg::*;
	logic live_reg, live_next, wr;
	logic [7:0] cfg_reg, cfg_next, sel_reg, sel_next;
	// Shadow copies follow bus writes so pin checks know the current mode.
	always_comb begin
		wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
		live_next = 1'b1;
		cfg_next = (wr && wb_adr_i == SPM_SYS_CONFIG_OFS) ? wb_dat_i[7:0] : cfg_reg;
		sel_next = (wr && wb_adr_i == SPM_IRQ_EDGE_PIN_SELECT_OFS) ? wb_dat_i[7:0] : sel_reg;
	end
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			live_reg <= 1'b0;
			cfg_reg <= SPM_SYS_CONFIG_RST;
			sel_reg <= SPM_IRQ_EDGE_PIN_SELECT_RST;
		end else begin
			live_reg <= live_next;
			cfg_reg <= cfg_next;
			sel_reg <= sel_next;
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_answer: assert property (live_reg && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("dat");
	a_pb_low_serial: assert property (live_reg && !$past(cfg_reg[5]) |-> pin_oe_o.port_b[0] &&
		pin_o.port_b[0] == $past(core_out_i.chan0_request_to_send_n)) else $error("pb0");
	a_pb_high_serial: assert property (live_reg && !$past(cfg_reg[6]) |-> pin_oe_o.port_b[5] &&
		pin_o.port_b[5] == $past(core_out_i.chan1_transmit)) else $error("pb5");
	a_pc_serial: assert property (live_reg && !$past(cfg_reg[7]) |-> pin_oe_o.port_c[5] &&
		pin_o.port_c[5] == $past(core_out_i.sync_a_wait_request_n)) else $error("pc5");
	a_strobe_pin: assert property (live_reg && !$past(sel_reg[3]) |-> pin_oe_o.port_c[2] &&
		pin_o.port_c[2] == $past(core_out_i.memory_write_strobe_n)) else $error("strobe");
	a_daisy_dir: assert property (live_reg |-> pin_oe_o.daisy == $past(sel_reg[2]))
		else $error("daisy");
	a_tri_host: assert property (live_reg && $past(cfg_reg[1]) |-> pin_oe_o.tri_fn == 3'b111 &&
		pin_o.tri_fn[0] == $past(core_out_i.host_interrupt_out)) else $error("tri");
	a_cts_forced: assert property (live_reg && $past(cfg_reg[5]) |->
		!core_in_o.chan0_clear_to_send_n) else $error("cts");
	c_host: cover property (live_reg && cfg_reg[1]);
	c_daisy: cover property (live_reg && sel_reg[2]);
	c_write: cover property (wr);
endmodule
bind spm_pin_mux spm_pin_mux_chk u_chk (.clk_sys_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_i, .pin_o, .pin_oe_o,
	.external_irq_one_n_i, .external_irq_two_n_i, .core_out_i, .core_in_o);

// file: spm_board_model.sv
`timescale 1ns/1ps
module spm_board_model (
	input wire spm_pkg::spm_pins_t pin_o_i,
	input wire spm_pkg::spm_pins_t pin_oe_i,
	input wire spm_pkg::spm_pins_t board_drive_i,
	output spm_pkg::spm_pins_t pin_i_o
);
	import spm_pkg::*;
	// The board drives every pin that the device leaves, so no pin floats.
	assign pin_i_o = (pin_o_i & pin_oe_i) | (board_drive_i & ~pin_oe_i);
endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
	import spm_pkg::*;
	logic clk_sys_i, reset_i, cyc, stb, we, ack, irq1_n, irq2_n;
	logic [7:0] adr, c, s, q;
	logic [3:0] sel;
	logic [31:0] dat, rdat;
	logic [63:0] rnd;
	spm_pins_t pin_i, pin_o, pin_oe, drv, e_o, e_oe, p;
	spm_core_out_t co;
	spm_core_in_t cin, e_in;
	int errors, compares, cycles;
	logic [7:0] r [6];
	localparam logic [7:0] OFS [6] = '{SPM_PORT_A_DATA_OFS, SPM_PORT_A_DIR_OFS,
		SPM_PORT_B_DATA_OFS, SPM_PORT_B_DIR_OFS, SPM_PORT_C_DATA_OFS, SPM_PORT_C_DIR_OFS};
	spm_pin_mux uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe),
		.external_irq_one_n_i(irq1_n), .external_irq_two_n_i(irq2_n), .core_out_i(co),
		.core_in_o(cin));
	spm_board_model board (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .board_drive_i(drv),
		.pin_i_o(pin_i));
	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	task automatic report_and_stop;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("ERROR %0t timeout", $time);
			report_and_stop;
		end
	end
	task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
		compares++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t %s got %h exp %h", $time, what, g, e);
		end
	endtask
	// Holds the request until ack is sampled high; the bench timeout ends a hang.
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] sl);
		@(posedge clk_sys_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= sl;
		dat <= {24'h00_0000, d};
		do @(posedge clk_sys_i); while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic expect_calc;
		e_o = '0;
		e_oe = '0;
		{e_o.port_a, e_oe.port_a} = c[1] ? {co.host_data_out, {8{co.host_data_oe}}} : {r[0], r[1]};
		e_o.port_b = r[2];
		e_oe.port_b = r[3];
		if (!c[6]) e_oe.port_b[7:5] = 3'b001;
		if (!c[6]) e_o.port_b[5] = co.chan1_transmit;
		if (!c[5]) e_oe.port_b[4:0] = 5'b01001;
		if (!c[5]) e_o.port_b[3] = co.chan0_transmit;
		if (!c[5]) e_o.port_b[0] = co.chan0_request_to_send_n;
		e_o.port_c = r[4][5:0];
		e_oe.port_c = r[5][5:0];
		if (!c[7]) e_oe.port_c = 6'b10_1100;
		if (!c[7]) e_o.port_c[5] = co.sync_a_wait_request_n;
		if (!c[7]) e_o.port_c[3] = co.sync_a_terminal_ready_request_n;
		if (!c[7]) e_o.port_c[2] = co.sync_a_request_to_send_n;
		if (!s[3]) e_oe.port_c[2] = 1'b1;
		if (!s[3]) e_o.port_c[2] = co.memory_write_strobe_n;
		e_o.tri_fn = c[1] ? {co.host_rx_ready_out_n, co.host_tx_ready_out_n, co.host_interrupt_out}
			: c[2] ? {co.sync_b_request_to_send_n, co.sync_b_wait_request_n,
			co.sync_b_terminal_ready_request_n} : co.primary_out;
		e_oe.tri_fn = (c[2:1] != 2'b00) ? 3'b111 : co.primary_oe;
		e_o.daisy = co.daisy_chain_out;
		e_oe.daisy = s[2];
		p = (e_o & e_oe) | (drv & ~e_oe);
		e_in = '0;
		e_in.chan0_receive = c[5] | p.port_b[4];
		e_in.chan0_clear_to_send_n = !c[5] & p.port_b[1];
		e_in.chan0_carrier_detect_n = c[5] | p.port_b[2];
		e_in.chan1_receive = c[6] | p.port_b[6];
		e_in.clocked_serial_rx_or_chan1_cts_n = c[6] | p.port_b[7];
		e_in.sync_a_clear_to_send_n = c[7] | p.port_c[1];
		e_in.sync_a_carrier_detect_n = c[7] | p.port_c[0];
		e_in.sync_a_sync_pin_n = c[7] | p.port_c[4];
		e_in.daisy_chain_in = s[2] | p.daisy;
		e_in.host_data_in = c[1] ? p.port_a : 8'h00;
		e_in.primary_in = (c[2:1] == 2'b00) ? p.tri_fn : 3'b000;
	endtask
	initial begin
		{reset_i, irq1_n, irq2_n} = 3'b111;
		{cyc, stb, we, adr, sel, dat} = '0;
		{co, drv} = '0;
		{errors, compares, cycles} = '0;
		void'($urandom(32'h23a7_df8b));
		repeat (8) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		wb(1'b0, SPM_SYS_CONFIG_OFS, 8'h00, 4'h1);
		check(q, SPM_SYS_CONFIG_RST, "config reset");
		wb(1'b0, SPM_IRQ_EDGE_PIN_SELECT_OFS, 8'h00, 4'h1);
		check(q, SPM_IRQ_EDGE_PIN_SELECT_RST, "select reset");
		wb(1'b1, 8'h40, 8'hFF, 4'h1);
		wb(1'b0, 8'h40, 8'h00, 4'h1);
		check(q, 8'h00, "unmapped");
		wb(1'b1, SPM_SYS_CONFIG_OFS, 8'hFF, 4'h0);
		wb(1'b0, SPM_SYS_CONFIG_OFS, 8'h00, 4'h1);
		check(q, 8'h00, "masked write");
		$display("test registers done");
		for (int i = 0; i < 16; i++) begin
			c = {i[2:0], 2'b00, i[3], i[1], 1'b0};
			s = {4'h0, i[0], i[2], 2'b00};
			wb(1'b1, SPM_SYS_CONFIG_OFS, c, 4'h1);
			wb(1'b1, SPM_IRQ_EDGE_PIN_SELECT_OFS, s, 4'h1);
			for (int k = 0; k < 6; k++) begin
				r[k] = 8'($urandom);
				wb(1'b1, OFS[k], r[k], 4'h1);
			end
			rnd = {$urandom, $urandom};
			@(posedge clk_sys_i);
			co <= rnd[28:0];
			drv <= rnd[59:30];
			irq1_n <= rnd[61];
			irq2_n <= rnd[62];
			repeat (4) @(posedge clk_sys_i);
			#1;
			expect_calc;
			check(32'(pin_oe), 32'(e_oe), "enables");
			check(32'(pin_o & e_oe), 32'(e_o & e_oe), "drive");
			check(32'(cin), 32'(e_in), "core inputs");
			wb(1'b0, SPM_PORT_B_DATA_OFS, 8'h00, 4'h1);
			check(q, p.port_b, "port b read");
			wb(1'b0, SPM_PORT_C_DATA_OFS, 8'h00, 4'h1);
			check(q, {rnd[62], rnd[61], p.port_c}, "port c read");
			wb(1'b0, SPM_SYS_CONFIG_OFS, 8'h00, 4'h1);
			check(q, c, "config read");
			wb(1'b0, SPM_IRQ_EDGE_PIN_SELECT_OFS, 8'h00, 4'h1);
			check(q, s, "select read");
			wb(1'b0, SPM_PORT_A_DATA_OFS, 8'h00, 4'h1);
			check(q, p.port_a, "port a read");
			// Direction registers hold what was written, whatever the pin mode.
			for (int k = 1; k < 6; k += 2) begin
				wb(1'b0, OFS[k], 8'h00, 4'h1);
				check(q, r[k], "direction read");
			end
		end
		$display("test mux done");
		report_and_stop;
	end
endmodule
